//--- ipc_prio_ctrl.v
// Operation
// - Priority code zero disables the source
// - Nonzero priority codes rank one through seven
// - Subpriority codes zero through three all valid
// - Slot zero fields at bits 4:2, 1:0
// - Slot one fields at bits 12:10, 9:8
// - Slot two fields at bits 20:18, 17:16
// - Slot three fields at bits 28:26, 25:24
// - Unused bits read zero, ignore writes
// - Request flag set when source requests
// - Flagged source forwarded only while enabled
`timescale 1ns/10ps
`include "ipc_defines.vh"

module ipc_prio_ctrl #(
	parameter NSLOT = 4
) (
	input  wire        clk,
	input  wire        nrst,
	input  wire [7:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	input  wire [3:0]  src_req,
	output reg         core_req,
	output reg  [1:0]  core_slot,
	output reg  [2:0]  core_priority,
	output reg  [1:0]  core_subpriority,
	output wire        irq
);

	reg  [31:0] prio_ctrl_q;
	reg  [3:0]  flag_q;
	reg  [3:0]  enable_q;
	reg  [1:0]  status_q;
	reg  [1:0]  irq_en_q;
	reg  [31:0] rdata_d;
	reg  [3:0]  flag_d;
	reg  [1:0]  status_d;
	reg         sel_req;
	reg  [1:0]  sel_slot;
	reg  [2:0]  sel_prio;
	reg  [1:0]  sel_sub;
	reg  [4:0]  best_key;
	reg  [4:0]  key;
	integer     i;

	function [2:0] slot_prio;
		input [31:0] word;
		input [1:0]  slot;
		begin
			slot_prio = word[{slot, 3'b000} + `IPC_PRIO_LSB +: 3];
		end
	endfunction

	function [1:0] slot_sub;
		input [31:0] word;
		input [1:0]  slot;
		begin
			slot_sub = word[{slot, 3'b000} + `IPC_SUB_LSB +: 2];
		end
	endfunction

	wire wr_prio  = wr && (addr == `IPC_PRIO_CTRL_OFS);
	wire wr_flag  = wr && (addr == `IPC_FLAG_OFS);
	wire wr_en    = wr && (addr == `IPC_ENABLE_OFS);
	wire wr_clr   = wr && (addr == `IPC_CLEAR_OFS);
	wire wr_irqen = wr && (addr == `IPC_IRQ_EN_OFS);
	wire wr_unmap = wr && !(wr_prio || wr_flag || wr_en || wr_clr || wr_irqen);

	// Arbitration: priority above subpriority, lower slot wins a full tie
	always @* begin
		sel_req  = 1'b0;
		sel_slot = 2'h0;
		sel_prio = 3'h0;
		sel_sub  = 2'h0;
		best_key = 5'h00;
		key      = 5'h00;
		for (i = 0; i < NSLOT; i = i + 1) begin
			key = {slot_prio(prio_ctrl_q, i[1:0]), slot_sub(prio_ctrl_q, i[1:0])};
			if (flag_q[i] && enable_q[i]
			    && (slot_prio(prio_ctrl_q, i[1:0]) != 3'h0)
			    && (!sel_req || key > best_key)) begin
				sel_req  = 1'b1;
				sel_slot = i[1:0];
				sel_prio = key[4:2];
				sel_sub  = key[1:0];
				best_key = key;
			end
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always @* begin
		flag_d = flag_q;
		if (wr_flag) begin
			flag_d = wdata[3:0];
		end
		flag_d = flag_d | src_req;
	end

	always @* begin
		status_d = status_q;
		if (wr_clr) begin
			status_d = status_q & ~wdata[1:0];
		end
		if (sel_req != core_req || sel_slot != core_slot) begin
			status_d[`IPC_EV_SEL_CHANGE] = 1'b1;
		end
		if (wr_unmap) begin
			status_d[`IPC_EV_WR_UNMAPPED] = 1'b1;
		end
	end

	always @* begin
		rdata_d = 32'h00000000;
		if (rd) begin
			case (addr)
				`IPC_PRIO_CTRL_OFS: rdata_d = prio_ctrl_q;
				`IPC_FLAG_OFS:      rdata_d = {28'h0000000, flag_q};
				`IPC_ENABLE_OFS:    rdata_d = {28'h0000000, enable_q};
				`IPC_STATUS_OFS:    rdata_d = {30'h00000000, status_q};
				`IPC_IRQ_EN_OFS:    rdata_d = {30'h00000000, irq_en_q};
				`IPC_SEL_OFS:       rdata_d = {24'h000000, core_req, core_slot, core_priority, core_subpriority};
				default:            rdata_d = 32'h00000000;
			endcase
		end
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prio_ctrl_q      <= `IPC_PRIO_CTRL_RST;
			flag_q           <= `IPC_FLAG_RST;
			enable_q         <= `IPC_ENABLE_RST;
			status_q         <= 2'h0;
			irq_en_q         <= 2'h0;
			rdata            <= 32'h00000000;
			core_req         <= 1'b0;
			core_slot        <= 2'h0;
			core_priority    <= 3'h0;
			core_subpriority <= 2'h0;
		end else begin
			if (wr_prio) begin
				// Unused bits above each slot are masked away
				prio_ctrl_q <= wdata & `IPC_SLOT_MASK;
			end
			if (wr_en) begin
				enable_q <= wdata[3:0];
			end
			if (wr_irqen) begin
				irq_en_q <= wdata[1:0];
			end
			flag_q           <= flag_d;
			status_q         <= status_d;
			rdata            <= rdata_d;
			core_req         <= sel_req;
			core_slot        <= sel_slot;
			core_priority    <= sel_prio;
			core_subpriority <= sel_sub;
		end
	end

	assign irq = |(status_q & irq_en_q);

endmodule // ipc_prio_ctrl

//--- ipc_defines.vh
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH

// Register offsets (byte addresses, one aligned word each)
`define IPC_PRIO_CTRL_OFS   8'h00
`define IPC_FLAG_OFS        8'h04
`define IPC_ENABLE_OFS      8'h08
`define IPC_STATUS_OFS      8'h0C
`define IPC_CLEAR_OFS       8'h10
`define IPC_IRQ_EN_OFS      8'h14
`define IPC_SEL_OFS         8'h18

// Slot layout inside the priority control word
`define IPC_SLOT_STRIDE     8
`define IPC_SUB_LSB         0
`define IPC_PRIO_LSB        2
`define IPC_SLOT_MASK       32'h1F1F1F1F

// Reset values
`define IPC_PRIO_CTRL_RST   32'h00000000
`define IPC_FLAG_RST        4'h0
`define IPC_ENABLE_RST      4'h0

// Event bits of the status register
`define IPC_EV_SEL_CHANGE   0
`define IPC_EV_WR_UNMAPPED  1

`endif

//--- ipc_src_model.sv
`timescale 1ns/10ps
module ipc_src_model (
	input            clk,
	input      [3:0] fire,
	output reg [3:0] src_req = 4'h0
);
	// Registered so a request never moves on the edge that samples it
	always @(posedge clk) src_req <= fire;
endmodule // ipc_src_model

//--- ipc_prio_ctrl_monitor.sv
`timescale 1ns/10ps
module ipc_prio_ctrl_monitor (
	input        clk,
	input        nrst,
	input [7:0]  addr,
	input        wr,
	input        rd,
	input [31:0] rdata,
	input [3:0]  src_req,
	input        core_req,
	input [1:0]  core_slot,
	input [2:0]  core_priority,
	input [1:0]  core_subpriority
);
	wire [7:0] sel = {core_req, core_slot, core_priority, core_subpriority};
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_pad_zero: assert property ($past(rd && !addr) |-> !(rdata & 32'hE0E0E0E0)) else $error("pad");
	a_rd_idle: assert property (!$past(rd) |-> !rdata) else $error("rdata");
	a_pri_live: assert property (core_req |-> core_priority) else $error("prio");
	a_pri_none: assert property (!core_req |-> !core_priority) else $error("none");
	// A cause reaches the flags on one edge and the registered selection on the next
	a_req_cause: assert property ($rose(core_req) |-> $past(wr || src_req, 2)) else $error("req");
	a_drop_cause: assert property ($fell(core_req) |-> $past(wr, 2)) else $error("drop");
	a_sel_hold: assert property (!$past(wr || src_req, 2) |-> $stable(sel)) else $error("hold");
	a_sel_read: assert property ($past(rd && addr == 8'h18) |-> rdata[7:0] == $past(sel)) else $error("sel");
endmodule // ipc_prio_ctrl_monitor
bind ipc_prio_ctrl ipc_prio_ctrl_monitor i_mon (.*);

//--- ipc_prio_ctrl_test.sv
`timescale 1ns/10ps
module ipc_prio_ctrl_test;
	reg         clk = 0, nrst = 0, wr = 0, rd = 0;
	reg  [3:0]  fire = 4'h0;
	reg  [7:0]  addr = 8'h0;
	reg  [31:0] wdata = 32'h0;
	wire [3:0]  src_req;
	wire [31:0] rdata;
	wire        irq;
	int         err_total = 0, samples_checked = 0;
	always #4 clk = ~clk;
	ipc_src_model i_src (.*);
	ipc_prio_ctrl i_dut (.*, .core_req(), .core_slot(), .core_priority(), .core_subpriority());
	task cmp(input string n, input [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
		@(posedge clk);
		{wr, rd} <= {w, !w};
		{addr, wdata} <= {a, d};
		@(posedge clk);
		{wr, rd} <= 2'h0;
		if (!w) #1 cmp("rdata", d, rdata);
	endtask
	task results;
		$display("checked %0d failed %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		#5000 err_total++;
		results;
	end
	initial begin
		repeat (6) @(posedge clk);
		nrst <= 1;
		bus(0, 8'h00, 32'h0);
		bus(1, 8'h00, 32'hF4E3EEED);
		bus(0, 8'h00, 32'h14030E0D);
		bus(1, 8'h08, 32'hF);
		fire <= 4'hF;
		@(posedge clk);
		fire <= 4'h0;
		@(posedge clk);
		bus(0, 8'h18, 32'hF4);
		bus(1, 8'h04, 32'h7);
		bus(0, 8'h18, 32'hAE);
		bus(1, 8'h08, 32'h4);
		bus(0, 8'h18, 32'h0);
		bus(0, 8'h40, 32'h0);
		$display("test select done");
		cmp("irq", 32'h0, irq);
		bus(1, 8'h14, 32'h1);
		#1 cmp("irq", 32'h1, irq);
		bus(1, 8'h10, 32'h1);
		#1 cmp("irq", 32'h0, irq);
		bus(1, 8'h40, 32'h0);
		bus(1, 8'h14, 32'h2);
		#1 cmp("irq", 32'h1, irq);
		$display("test irq done");
		results;
	end
endmodule // ipc_prio_ctrl_test
